// ==== common/lvpm_pkg.sv ====
// Package with register map, field positions and reset values for the power management block
package lvpm_pkg;
   // Register byte addresses
   localparam logic [11:0] LVPM_SUPPLY_OFS  = 12'h000;
   localparam logic [11:0] LVPM_POWER_OFS   = 12'h004;
   localparam logic [11:0] LVPM_IRQ_STS_OFS = 12'h008;
   localparam logic [11:0] LVPM_IRQ_EN_OFS  = 12'h00C;
   localparam logic [11:0] LVPM_IRQ_CLR_OFS = 12'h010;
   // Supply monitor register fields
   localparam int LVPM_WARN_FLAG_BIT  = 7;
   localparam int LVPM_WARN_ACK_BIT   = 6;
   localparam int LVPM_WARN_IE_BIT    = 5;
   localparam int LVPM_DET_RST_BIT    = 4;
   localparam int LVPM_DET_STOP_BIT   = 3;
   localparam int LVPM_DET_EN_BIT     = 2;
   localparam int LVPM_REF_BUF_BIT    = 0;
   // Power down register fields
   localparam int LVPM_DET_VSEL_BIT   = 5;
   localparam int LVPM_WARN_VSEL_BIT  = 4;
   localparam int LVPM_PPD_FLAG_BIT   = 3;
   localparam int LVPM_PPD_ACK_BIT    = 2;
   localparam int LVPM_PPD_SEL_BIT    = 0;
   // Interrupt status fields
   localparam int LVPM_EV_WARN_BIT    = 0;
   localparam int LVPM_EV_WAKE_BIT    = 1;
   localparam int LVPM_EV_W           = 2;
   // Reset values
   localparam logic       LVPM_CTRL_RST   = 1'b0;
   localparam logic [1:0] LVPM_EV_RST     = 2'h0;
   localparam logic [1:0] LVPM_TRIP_RST   = 2'h0;
   // Bus constants
   localparam logic [1:0] LVPM_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] LVPM_HTRANS_SEQ    = 2'h3;
   localparam logic [1:0] LVPM_HRESP_OKAY    = 2'h0;
endpackage

// ==== src/lvpm_ctrl.sv ====
// Low-voltage power management control and status block with an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: Warning flag sets on low supply, also after reset
// RULE2: Bit 7 reads warning present or latched
// RULE3: Warning ack clears flag only when supply recovered
// RULE4: Warning interrupt enable asserts request while flagged
// RULE5: Write-once reset enable forces reset on detect
// RULE6: Stop enable keeps detection running in stop
// RULE7: Write-once detect enable gates detect logic
// RULE8: Bit 0 drives bandgap reference buffer enable
// RULE9: Write-once bits accept first write after reset
// RULE10: Non-power-on resets keep trip point selects
// RULE11: Write-once detect select picks detect range
// RULE12: Warning select picks point within range
// RULE13: Partial down flag set after partial-down wake
// RULE14: Partial down ack clears flag, reads zero
// RULE15: Write-once select picks stop mode kind
// RULE16: Software writes both registers after every reset
// RULE17: Comparator outputs pass two-stage synchronizer
module lvpm_ctrl
   import lvpm_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        por_n,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic      [1:0]  hresp,
   input  wire logic        undervolt_warning,
   input  wire logic        undervolt_detect,
   input  wire logic        stop_active,
   input  wire logic        partial_down_wake,
   output logic             undervolt_detect_reset_req,
   output logic             undervolt_detect_active,
   output logic             reference_buffer_en,
   output logic      [1:0]  trip_select,
   output logic             partial_down_select,
   output logic             undervolt_warning_irq,
   output logic             irq
);
   logic       rst_s1, rst_sync_n;
   logic       por_s1, por_sync_n;
   logic [1:0] warn_sync, det_sync;
   logic       wr_pend;
   logic [11:0] wr_addr;
   logic       undervolt_warning_flag, undervolt_warning_irq_en;
   logic       undervolt_detect_reset_en, undervolt_detect_stop_en, undervolt_detect_en;
   logic       reference_buffer_en_r;
   logic       detect_voltage_select, warning_voltage_select;
   logic       partial_down_wake_flag, partial_down_select_r;
   logic [1:0] wonce_sup;
   logic [1:0] wonce_pwr;
   logic [LVPM_EV_W-1:0] ev_sts, ev_en, ev_set, ev_clr;
   logic       warn_now, det_now, det_live;
   logic       wr_sup, wr_pwr, wr_clr, wr_en;
   logic       bus_take;

   function automatic logic sel_reg(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   // Reset release through two flops; power-on reset separately
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1     <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1     <= 1'b1;
         rst_sync_n <= rst_s1;
      end
   end

   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         por_s1     <= 1'b0;
         por_sync_n <= 1'b0;
      end else begin
         por_s1     <= 1'b1;
         por_sync_n <= por_s1;
      end
   end

   // Comparator synchronizers
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         warn_sync <= 2'h0;
         det_sync  <= 2'h0;
      end else begin
         warn_sync <= {warn_sync[0], undervolt_warning}; // RULE17
         det_sync  <= {det_sync[0], undervolt_detect}; // RULE17
      end
   end
   assign warn_now = warn_sync[1];
   assign det_now  = det_sync[1];

   // AHB-Lite address phase capture; writes complete with zero wait states
   assign bus_take = hsel && hready && (htrans == LVPM_HTRANS_NONSEQ || htrans == LVPM_HTRANS_SEQ);

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else begin
         wr_pend <= bus_take && hwrite;
         if (bus_take) begin
            wr_addr <= haddr;
         end
      end
   end

   assign wr_sup = wr_pend && sel_reg(wr_addr, LVPM_SUPPLY_OFS);
   assign wr_pwr = wr_pend && sel_reg(wr_addr, LVPM_POWER_OFS);
   assign wr_en  = wr_pend && sel_reg(wr_addr, LVPM_IRQ_EN_OFS);
   assign wr_clr = wr_pend && sel_reg(wr_addr, LVPM_IRQ_CLR_OFS);

   // Read data registered in the address phase
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= LVPM_HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= LVPM_HRESP_OKAY;
         if (bus_take && !hwrite) begin
            hrdata <= 32'h0000_0000;
            if (sel_reg(haddr, LVPM_SUPPLY_OFS)) begin
               hrdata[LVPM_WARN_FLAG_BIT] <= undervolt_warning_flag; // RULE2
               hrdata[LVPM_WARN_IE_BIT]   <= undervolt_warning_irq_en;
               hrdata[LVPM_DET_RST_BIT]   <= undervolt_detect_reset_en;
               hrdata[LVPM_DET_STOP_BIT]  <= undervolt_detect_stop_en;
               hrdata[LVPM_DET_EN_BIT]    <= undervolt_detect_en;
               hrdata[LVPM_REF_BUF_BIT]   <= reference_buffer_en_r;
            end else if (sel_reg(haddr, LVPM_POWER_OFS)) begin
               hrdata[LVPM_DET_VSEL_BIT]  <= detect_voltage_select;
               hrdata[LVPM_WARN_VSEL_BIT] <= warning_voltage_select;
               hrdata[LVPM_PPD_FLAG_BIT]  <= partial_down_wake_flag; // RULE13
               hrdata[LVPM_PPD_SEL_BIT]   <= partial_down_select_r; // RULE15
            end else if (sel_reg(haddr, LVPM_IRQ_STS_OFS)) begin
               hrdata[LVPM_EV_W-1:0] <= ev_sts;
            end else if (sel_reg(haddr, LVPM_IRQ_EN_OFS)) begin
               hrdata[LVPM_EV_W-1:0] <= ev_en;
            end
         end
      end
   end

   // Warning flag: hardware set wins over acknowledge
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         undervolt_warning_flag <= LVPM_CTRL_RST;
      end else if (warn_now) begin
         undervolt_warning_flag <= 1'b1; // RULE1
      end else if (wr_sup && hwdata[LVPM_WARN_ACK_BIT]) begin
         undervolt_warning_flag <= 1'b0; // RULE3
      end
   end

   // Supply monitor controls; write-once bits lock on first write
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         undervolt_warning_irq_en  <= LVPM_CTRL_RST;
         undervolt_detect_reset_en <= LVPM_CTRL_RST;
         undervolt_detect_stop_en  <= LVPM_CTRL_RST;
         undervolt_detect_en       <= LVPM_CTRL_RST;
         reference_buffer_en_r     <= LVPM_CTRL_RST;
         wonce_sup                 <= 2'h0;
      end else if (wr_sup) begin
         undervolt_warning_irq_en <= hwdata[LVPM_WARN_IE_BIT];
         undervolt_detect_stop_en <= hwdata[LVPM_DET_STOP_BIT];
         reference_buffer_en_r    <= hwdata[LVPM_REF_BUF_BIT];
         if (!wonce_sup[0]) begin
            undervolt_detect_reset_en <= hwdata[LVPM_DET_RST_BIT]; // RULE9
            wonce_sup[0]              <= 1'b1;
         end
         if (!wonce_sup[1]) begin
            undervolt_detect_en <= hwdata[LVPM_DET_EN_BIT]; // RULE9
            wonce_sup[1]        <= 1'b1;
         end
      end
   end

   // Trip selects reset only on power-on
   always_ff @(posedge ref_clk or negedge por_sync_n) begin
      if (!por_sync_n) begin
         {detect_voltage_select, warning_voltage_select} <= LVPM_TRIP_RST; // RULE10
      end else if (!rst_sync_n) begin
         detect_voltage_select  <= detect_voltage_select;
      end else if (wr_pwr) begin
         warning_voltage_select <= hwdata[LVPM_WARN_VSEL_BIT]; // RULE12
         if (!wonce_pwr[0]) begin
            detect_voltage_select <= hwdata[LVPM_DET_VSEL_BIT]; // RULE11
         end
      end
   end

   // Power down register controls and wake flag
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         partial_down_select_r <= LVPM_CTRL_RST;
         partial_down_wake_flag <= LVPM_CTRL_RST;
         wonce_pwr             <= 2'h0;
      end else begin
         if (partial_down_wake) begin
            partial_down_wake_flag <= 1'b1; // RULE13
         end else if (wr_pwr && hwdata[LVPM_PPD_ACK_BIT]) begin
            partial_down_wake_flag <= 1'b0; // RULE14
         end
         if (wr_pwr) begin
            wonce_pwr[0] <= 1'b1; // RULE9
            if (!wonce_pwr[1]) begin
               partial_down_select_r <= hwdata[LVPM_PPD_SEL_BIT]; // RULE15
               wonce_pwr[1]          <= 1'b1;
            end
         end
      end
   end

   // Detect gating and block outputs
   assign det_live = undervolt_detect_en && (!stop_active || undervolt_detect_stop_en); // RULE6 RULE7

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         undervolt_detect_reset_req <= 1'b0;
         undervolt_detect_active    <= 1'b0;
         reference_buffer_en        <= 1'b0;
         partial_down_select        <= 1'b0;
         undervolt_warning_irq      <= 1'b0;
         irq                        <= 1'b0;
      end else begin
         undervolt_detect_reset_req <= det_live && undervolt_detect_reset_en && det_now; // RULE5
         undervolt_detect_active    <= det_live; // RULE7
         reference_buffer_en        <= reference_buffer_en_r; // RULE8
         partial_down_select        <= partial_down_select_r; // RULE15
         undervolt_warning_irq      <= undervolt_warning_irq_en && undervolt_warning_flag; // RULE4
         irq                        <= |(ev_sts & ev_en);
      end
   end

   always_ff @(posedge ref_clk or negedge por_sync_n) begin
      if (!por_sync_n) begin
         trip_select <= LVPM_TRIP_RST;
      end else begin
         trip_select <= {detect_voltage_select, warning_voltage_select}; // RULE12
      end
   end

   // Event status, enable and clear; a set wins over a clear
   assign ev_set[LVPM_EV_WARN_BIT] = warn_now;
   assign ev_set[LVPM_EV_WAKE_BIT] = partial_down_wake;
   assign ev_clr = wr_clr ? hwdata[LVPM_EV_W-1:0] : LVPM_EV_RST;

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ev_sts <= LVPM_EV_RST;
         ev_en  <= LVPM_EV_RST;
      end else begin
         ev_sts <= ev_set | (ev_sts & ~ev_clr);
         if (wr_en) begin
            ev_en <= hwdata[LVPM_EV_W-1:0];
         end
      end
   end

   property p_warn_set;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      warn_now |=> undervolt_warning_flag;
   endproperty
   a_warn_set: assert property (p_warn_set) else $error("warning flag not set"); // RULE1

   property p_warn_hold;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      (undervolt_warning_flag && warn_now) |=> undervolt_warning_flag;
   endproperty
   a_warn_hold: assert property (p_warn_hold) else $error("warning flag cleared while low"); // RULE3

   property p_irq_out;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      (undervolt_warning_irq_en && undervolt_warning_flag) |=> undervolt_warning_irq;
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("warning irq missing"); // RULE4

   property p_no_reset;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      !undervolt_detect_reset_en |=> !undervolt_detect_reset_req;
   endproperty
   a_no_reset: assert property (p_no_reset) else $error("reset without enable"); // RULE5

   property p_stop_gate;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      (stop_active && !undervolt_detect_stop_en) |=> !undervolt_detect_active;
   endproperty
   a_stop_gate: assert property (p_stop_gate) else $error("detect active in stop"); // RULE6

   property p_once;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      wonce_sup[1] |=> $stable(undervolt_detect_en);
   endproperty
   a_once: assert property (p_once) else $error("write-once bit changed"); // RULE9

   property p_ppd_set;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      partial_down_wake |=> partial_down_wake_flag;
   endproperty
   a_ppd_set: assert property (p_ppd_set) else $error("wake flag not set"); // RULE13

   property p_ppd_ack;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      (wr_pwr && hwdata[LVPM_PPD_ACK_BIT] && !partial_down_wake) |=> !partial_down_wake_flag;
   endproperty
   a_ppd_ack: assert property (p_ppd_ack) else $error("wake flag not cleared"); // RULE14

   property p_sync;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      $rose(undervolt_warning) |=> ##1 warn_now;
   endproperty
   a_sync: assert property (p_sync) else $error("synchronizer latency wrong"); // RULE17

   property p_warn_ack;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      (undervolt_warning_flag && !warn_now && wr_sup && hwdata[LVPM_WARN_ACK_BIT])
         |=> !undervolt_warning_flag;
   endproperty
   a_warn_ack: assert property (p_warn_ack) else $error("warning ack ignored"); // RULE3

   property p_irq_off;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      !undervolt_warning_irq_en |=> !undervolt_warning_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("warning irq while disabled"); // RULE4

   property p_reset_req;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      (det_live && undervolt_detect_reset_en && det_now) |=> undervolt_detect_reset_req;
   endproperty
   a_reset_req: assert property (p_reset_req) else $error("detect reset missing"); // RULE5

   property p_ref_buf;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      wr_sup |=> ##1 (reference_buffer_en == $past(hwdata[LVPM_REF_BUF_BIT], 2));
   endproperty
   a_ref_buf: assert property (p_ref_buf) else $error("buffer enable wrong"); // RULE8

   property p_once_rst;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      wonce_sup[0] |=> $stable(undervolt_detect_reset_en);
   endproperty
   a_once_rst: assert property (p_once_rst) else $error("reset enable changed"); // RULE9

   property p_trip_kept;
      @(posedge ref_clk) disable iff (!por_sync_n)
      !rst_sync_n |=> $stable({detect_voltage_select, warning_voltage_select});
   endproperty
   a_trip_kept: assert property (p_trip_kept) else $error("trip select lost"); // RULE10

   property p_once_dsel;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      wonce_pwr[0] |=> $stable(detect_voltage_select);
   endproperty
   a_once_dsel: assert property (p_once_dsel) else $error("detect select changed"); // RULE11

   property p_once_ppd;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      wonce_pwr[1] |=> $stable(partial_down_select_r);
   endproperty
   a_once_ppd: assert property (p_once_ppd) else $error("stop mode select changed"); // RULE15
endmodule // lvpm_ctrl
`default_nettype wire

// ==== tb/lvpm_supply_model.sv ====
// Far-side model of the supply comparators and the stop mode controller
`timescale 1ns/1ps
`default_nettype none
module lvpm_supply_model #(
   parameter int CMP_NS   = 13,
   parameter int WAKE_CYC = 2
) (
   input  wire logic ref_clk,
   input  wire logic warn_low,
   input  wire logic det_low,
   input  wire logic stop_req,
   input  wire logic partial_down_select,
   output logic      undervolt_warning,
   output logic      undervolt_detect,
   output logic      stop_active,
   output logic      partial_down_wake
);
   logic ppd_entered;
   initial begin
      undervolt_warning = 1'b0;
      undervolt_detect = 1'b0;
      stop_active = 1'b0;
      partial_down_wake = 1'b0;
      ppd_entered = 1'b0;
   end
   // Comparators switch off the clock edge, after an analog delay
   always @(warn_low) undervolt_warning <= #(CMP_NS) warn_low;
   always @(det_low) undervolt_detect <= #(CMP_NS) det_low;
   // Wake pulse only when the partial power down mode was chosen at entry
   always @(posedge ref_clk) begin
      if (stop_req && !stop_active) begin
         ppd_entered <= partial_down_select;
         stop_active <= 1'b1;
      end else if (!stop_req && stop_active) begin
         stop_active <= 1'b0;
         if (ppd_entered) begin
            repeat (WAKE_CYC) @(posedge ref_clk);
            partial_down_wake <= 1'b1;
            @(posedge ref_clk);
            partial_down_wake <= 1'b0;
         end
      end
   end
endmodule // lvpm_supply_model
`default_nettype wire

// ==== tb/lvpm_ctrl_tb.sv ====
// Self-checking testbench for the power management control block
`timescale 1ns/1ps
`default_nettype none
module lvpm_ctrl_tb;
   import lvpm_pkg::*;
   logic        ref_clk = 1'b0, rst_n = 1'b0, por_n = 1'b0;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0, hresp, trip_select;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] hwdata = 32'h0000_0000, hrdata;
   logic        hreadyout, warn_low = 1'b0, det_low = 1'b0, stop_req = 1'b0;
   logic        undervolt_warning, undervolt_detect, stop_active, partial_down_wake;
   logic        undervolt_detect_reset_req, undervolt_detect_active, reference_buffer_en;
   logic        partial_down_select, undervolt_warning_irq, irq;
   int          n_errors = 0, n_compared = 0;

   always #25 ref_clk = ~ref_clk;

   lvpm_ctrl u_lvpm_ctrl (.ref_clk, .rst_n, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .undervolt_warning,
      .undervolt_detect, .stop_active, .partial_down_wake, .undervolt_detect_reset_req,
      .undervolt_detect_active, .reference_buffer_en, .trip_select, .partial_down_select,
      .undervolt_warning_irq, .irq);
   lvpm_supply_model u_lvpm_supply_model (.ref_clk, .warn_low, .det_low, .stop_req,
      .partial_down_select, .undervolt_warning, .undervolt_detect, .stop_active,
      .partial_down_wake);

   task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_pin(input string what, input logic exp, input logic got);
      chk_reg(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= LVPM_HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk_reg("hresp", {30'h0000_0000, LVPM_HRESP_OKAY}, {30'h0000_0000, hresp});
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] unused;
      bus(1'b1, a, d, unused);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string what);
      logic [31:0] got;
      bus(1'b0, a, 8'h00, got);
      chk_reg(what, {24'h00_0000, exp}, got);
   endtask
   task automatic do_reset(input logic power_on);
      rst_n <= 1'b0;
      por_n <= ~power_on;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic t_regs;
      do_reset(1'b1);
      rdc(LVPM_SUPPLY_OFS, 8'h00, "supply_por");
      rdc(LVPM_POWER_OFS, 8'h00, "power_por");
      wr(LVPM_SUPPLY_OFS, 8'h1D);
      wr(LVPM_POWER_OFS, 8'h00);
      chk_pin("ref_buf_on", 1'b1, reference_buffer_en);
      chk_pin("detect_on", 1'b1, undervolt_detect_active);
      wr(LVPM_SUPPLY_OFS, 8'h00);
      rdc(LVPM_SUPPLY_OFS, 8'h14, "supply_locked");
      chk_pin("ref_buf_off", 1'b0, reference_buffer_en);
      wr(LVPM_POWER_OFS, 8'h31);
      rdc(LVPM_POWER_OFS, 8'h10, "power_locked");
      wr(12'h020, 8'hFF);
      rdc(12'h020, 8'h00, "unmapped");
   endtask

   task automatic t_warn;
      do_reset(1'b1);
      wr(LVPM_SUPPLY_OFS, 8'h20);
      wr(LVPM_IRQ_EN_OFS, 8'h01);
      warn_low <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rdc(LVPM_SUPPLY_OFS, 8'hA0, "warn_set");
      chk_pin("warn_irq", 1'b1, undervolt_warning_irq);
      chk_pin("irq_warn", 1'b1, irq);
      wr(LVPM_SUPPLY_OFS, 8'h60);
      rdc(LVPM_SUPPLY_OFS, 8'hA0, "ack_while_low");
      warn_low <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rdc(LVPM_SUPPLY_OFS, 8'hA0, "warn_latched");
      wr(LVPM_SUPPLY_OFS, 8'h60);
      wr(LVPM_IRQ_CLR_OFS, 8'h01);
      rdc(LVPM_SUPPLY_OFS, 8'h20, "warn_acked");
      chk_pin("warn_irq_off", 1'b0, undervolt_warning_irq);
      chk_pin("irq_off", 1'b0, irq);
      wr(LVPM_SUPPLY_OFS, 8'h00);
      warn_low <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk_pin("warn_irq_polled", 1'b0, undervolt_warning_irq);
      rdc(LVPM_IRQ_STS_OFS, 8'h01, "warn_event");
      wr(LVPM_IRQ_EN_OFS, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk_pin("irq_masked", 1'b0, irq);
      warn_low <= 1'b0;
   endtask

   task automatic t_detect;
      logic [7:0] cfg [3] = '{8'h14, 8'h04, 8'h10};
      for (int i = 0; i < 3; i++) begin
         do_reset(1'b1);
         wr(LVPM_SUPPLY_OFS, cfg[i]);
         det_low <= 1'b1;
         repeat (6) @(posedge ref_clk);
         chk_pin("reset_req", cfg[i] == 8'h14, undervolt_detect_reset_req);
         chk_pin("detect_active", cfg[i][2], undervolt_detect_active);
         det_low <= 1'b0;
      end
      do_reset(1'b1);
      wr(LVPM_SUPPLY_OFS, 8'h1C);
      det_low <= 1'b1;
      stop_req <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk_pin("reset_req_stop", 1'b1, undervolt_detect_reset_req);
      wr(LVPM_SUPPLY_OFS, 8'h14);
      repeat (3) @(posedge ref_clk);
      chk_pin("reset_req_stop_off", 1'b0, undervolt_detect_reset_req);
      chk_pin("detect_stop_off", 1'b0, undervolt_detect_active);
      stop_req <= 1'b0;
      det_low <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rdc(LVPM_POWER_OFS, 8'h00, "no_wake_flag");
   endtask

   task automatic t_wake;
      do_reset(1'b1);
      wr(LVPM_SUPPLY_OFS, 8'h00);
      wr(LVPM_POWER_OFS, 8'h01);
      wr(LVPM_IRQ_EN_OFS, 8'h02);
      chk_pin("ppd_select", 1'b1, partial_down_select);
      stop_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      stop_req <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk_pin("irq_wake", 1'b1, irq);
      rdc(LVPM_POWER_OFS, 8'h09, "wake_flag");
      rdc(LVPM_IRQ_STS_OFS, 8'h02, "wake_event");
      wr(LVPM_POWER_OFS, 8'h04);
      wr(LVPM_IRQ_CLR_OFS, 8'h02);
      rdc(LVPM_POWER_OFS, 8'h01, "wake_acked");
      rdc(LVPM_IRQ_STS_OFS, 8'h00, "wake_cleared");
      chk_pin("irq_cleared", 1'b0, irq);
   endtask

   task automatic t_trip;
      for (int i = 0; i < 4; i++) begin
         do_reset(1'b1);
         wr(LVPM_POWER_OFS, {2'b00, i[1:0], 4'h0});
         repeat (2) @(posedge ref_clk);
         chk_reg("trip_select", i, {30'h0000_0000, trip_select});
      end
      warn_low <= 1'b1;
      do_reset(1'b0);
      rdc(LVPM_POWER_OFS, 8'h30, "trip_kept");
      rdc(LVPM_SUPPLY_OFS, 8'h80, "warn_after_reset");
      wr(LVPM_POWER_OFS, 8'h00);
      rdc(LVPM_POWER_OFS, 8'h00, "detect_sel_rewritten");
      warn_low <= 1'b0;
   endtask

   task automatic report_and_stop;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      report_and_stop;
   end

   initial begin
      t_regs;
      t_warn;
      t_detect;
      t_wake;
      t_trip;
      report_and_stop;
   end
endmodule // lvpm_ctrl_tb
`default_nettype wire
